/* File: inc/vbird_regs.vh */
`ifndef VBIRD_REGS_VH
`define VBIRD_REGS_VH

// Mode control register: reset value and field positions
`define VBIRD_CTRL_RESET        8'h00
`define VBIRD_CTRL_FMT_BIT      0
`define VBIRD_CTRL_ACQ_BIT      1
`define VBIRD_CTRL_HDT_BIT      2
`define VBIRD_CTRL_TEST_LSB     3
`define VBIRD_CTRL_TEST_MSB     7

// Bus addresses as 7-bit slave addresses (write byte 20h/22h, read 21h/23h)
`define VBIRD_SLAVE_ADDR_LOW    7'h10
`define VBIRD_SLAVE_ADDR_HIGH   7'h11

// Readable range and bit counts
`define VBIRD_MAX_BYTES         4'hD
`define VBIRD_BITS_PER_BYTE     4'h8

// Data views decoded from the control register
`define VBIRD_VIEW_VPS          2'h0
`define VBIRD_VIEW_FMT2         2'h1
`define VBIRD_VIEW_FMT1         2'h2
`define VBIRD_VIEW_HDR          2'h3

// Kinds of output byte composition
`define VBIRD_KIND_FULL         2'h0
`define VBIRD_KIND_NIBS         2'h1
`define VBIRD_KIND_NIB_ONES     2'h2
`define VBIRD_KIND_ONES         2'h3

// Store layout: bank bit selects the format 2 packet
`define VBIRD_BANK_FMT2         7'h40

`endif

/* File: core/vbird_i2c_readout.v */
`timescale 1ns/100ps
// Overview of operation
// - Device acknowledges own address on ninth pulse.
// - Write: one data byte loads control, acknowledged.
// - Control register clears to zero at reset.
// - Control bit 1 selects VPS or PDC.
// - Bit 0 selects format 2 or format 1/header.
// - Bit 2 selects format 1 or header time.
// - Start resets byte pointer; thirteen bytes maximum.
// - Read: device sends addressed byte, MSB first.
// - Master acknowledge advances pointer, next byte.
// - Master not-acknowledge releases SDA, receive mode.
// - First-received source bit goes out in bit 7.
// - Format 1 order: 15-21, 13-14, 22-25.
// - Format 2 nibble pairs 16/17 through 22/23.
// - Format 2: 14/15, 24/25, 13 plus ones.
// - VPS order: 11-14, 5, 15, then ones.
// - Header time: header bytes 38 to 45.
// - Addresses 20h/21h or 22h/23h by select input.
// - No data update while bus access runs.
`include "vbird_regs.vh"

module vbird_i2c_readout #(
   parameter STORE_DEPTH = 128             // Source byte store, two banks of 64
) (
   input  wire       CLK_SYS,
   input  wire       RST_N,
   input  wire       SCL_I,
   input  wire       SDA_I,
   input  wire       ADDRESS_SELECT_INPUT,
   input  wire       ACQ_WE,
   input  wire [6:0] ACQ_ADDR,
   input  wire [7:0] ACQ_DATA,
   input  wire       ACQ_COMMIT,
   output reg        SDA_O,
   output reg        SDA_OE,
   output reg  [7:0] MODE_CONTROL,
   output reg        BUS_BUSY,
   output reg        DATA_UPDATED
);

   // Bus protocol states
   localparam ST_IDLE  = 3'h0;             // Waiting for start
   localparam ST_ADDR  = 3'h1;             // Shifting in address byte
   localparam ST_AACK  = 3'h2;             // Driving address acknowledge
   localparam ST_WDATA = 3'h3;             // Shifting in control byte
   localparam ST_WACK  = 3'h4;             // Driving data acknowledge
   localparam ST_RDATA = 3'h5;             // Sending a byte
   localparam ST_RACK  = 3'h6;             // Sampling master acknowledge
   localparam ST_SKIP  = 3'h7;             // Released until stop

   // Pin synchronisers, two flops each
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg [1:0] sel_sync;
   reg       scl_q;                        // Previous synced SCL
   reg       sda_q;                        // Previous synced SDA

   // Protocol state
   reg [2:0] state;
   reg [3:0] bit_cnt;                      // Bits seen in current byte
   reg [7:0] rx_shift;                     // Incoming byte
   reg [7:0] tx_shift;                     // Outgoing byte
   reg       rd_dir;                       // Address byte asked for read
   reg       master_acknowledge;           // Master pulled SDA low in ack slot
   reg [3:0] byte_ptr;                     // Output byte pointer, 0-based
   reg       commit_pending;               // Acquired line waiting for bus idle

   // Source byte stores: acquisition staging and readable transfer copy
   reg [7:0] stage_mem [0:STORE_DEPTH-1];
   reg [7:0] xfer_mem  [0:STORE_DEPTH-1];

   wire scl_s = scl_sync[1];
   wire sda_s = sda_sync[1];
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
   wire [1:0] data_view = view_of(MODE_CONTROL);
   wire       copy_now = commit_pending & (state == ST_IDLE);

   // Reverse bit order so the first-received bit leads
   function [7:0] rev8;
      input [7:0] b;
      begin
         rev8 = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      end
   endfunction

   // Same for a decoded four-bit group
   function [3:0] rev4;
      input [3:0] b;
      begin
         rev4 = {b[0], b[1], b[2], b[3]};
      end
   endfunction

   // Data view from the control register
   function [1:0] view_of;
      input [7:0] ctrl;
      begin
         if (!ctrl[`VBIRD_CTRL_ACQ_BIT]) begin
            view_of = `VBIRD_VIEW_VPS;
         end else if (!ctrl[`VBIRD_CTRL_FMT_BIT]) begin
            view_of = `VBIRD_VIEW_FMT2;
         end else if (!ctrl[`VBIRD_CTRL_HDT_BIT]) begin
            view_of = `VBIRD_VIEW_FMT1;
         end else begin
            view_of = `VBIRD_VIEW_HDR;
         end
      end
   endfunction

   // Map view and pointer to {kind, first source, second source}
   function [15:0] src_sel;
      input [1:0] view;
      input [3:0] ptr;
      reg   [6:0] p;
      begin
         p = {3'h0, ptr};
         src_sel = {`VBIRD_KIND_ONES, 7'h00, 7'h00};
         case (view)
            `VBIRD_VIEW_VPS: begin
               case (ptr)
                  4'h0, 4'h1, 4'h2, 4'h3:
                     src_sel = {`VBIRD_KIND_FULL, 7'd11 + p, 7'h00};
                  4'h4: src_sel = {`VBIRD_KIND_FULL, 7'd5, 7'h00};
                  4'h5: src_sel = {`VBIRD_KIND_FULL, 7'd15, 7'h00};
                  default: src_sel = {`VBIRD_KIND_ONES, 7'h00, 7'h00};
               endcase
            end
            `VBIRD_VIEW_FMT2: begin
               case (ptr)
                  4'h0, 4'h1, 4'h2, 4'h3:
                     src_sel = {`VBIRD_KIND_NIBS,
                                `VBIRD_BANK_FMT2 + 7'd16 + (p << 1),
                                `VBIRD_BANK_FMT2 + 7'd17 + (p << 1)};
                  4'h4: src_sel = {`VBIRD_KIND_NIBS, `VBIRD_BANK_FMT2 + 7'd14,
                                   `VBIRD_BANK_FMT2 + 7'd15};
                  4'h5: src_sel = {`VBIRD_KIND_NIBS, `VBIRD_BANK_FMT2 + 7'd24,
                                   `VBIRD_BANK_FMT2 + 7'd25};
                  4'h6: src_sel = {`VBIRD_KIND_NIB_ONES, `VBIRD_BANK_FMT2 + 7'd13, 7'h00};
                  default: src_sel = {`VBIRD_KIND_ONES, 7'h00, 7'h00};
               endcase
            end
            `VBIRD_VIEW_FMT1: begin
               if (ptr < 4'h7) begin
                  src_sel = {`VBIRD_KIND_FULL, 7'd15 + p, 7'h00};
               end else if (ptr < 4'h9) begin
                  src_sel = {`VBIRD_KIND_FULL, 7'd6 + p, 7'h00};
               end else if (ptr < `VBIRD_MAX_BYTES) begin
                  src_sel = {`VBIRD_KIND_FULL, 7'd13 + p, 7'h00};
               end else begin
                  src_sel = {`VBIRD_KIND_ONES, 7'h00, 7'h00};
               end
            end
            default: begin
               if (ptr < 4'h8) begin
                  src_sel = {`VBIRD_KIND_FULL, 7'd38 + p, 7'h00};
               end else begin
                  src_sel = {`VBIRD_KIND_ONES, 7'h00, 7'h00};
               end
            end
         endcase
      end
   endfunction

   // Compose the byte the pointer addresses in the current view
   reg [15:0] sel;
   reg [7:0]  out_byte;
   always @* begin
      sel = src_sel(data_view, byte_ptr);
      case (sel[15:14])
         `VBIRD_KIND_FULL:
            out_byte = rev8(xfer_mem[sel[13:7]]);
         `VBIRD_KIND_NIBS:
            out_byte = {rev4(xfer_mem[sel[13:7]][3:0]), rev4(xfer_mem[sel[6:0]][3:0])};
         `VBIRD_KIND_NIB_ONES:
            out_byte = {rev4(xfer_mem[sel[13:7]][3:0]), 4'hF};
         default:
            out_byte = 8'hFF;
      endcase
   end

   // Synchronise pins; first flops feed only second flops
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         sel_sync <= 2'h0;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], SCL_I};
         sda_sync <= {sda_sync[0], SDA_I};
         sel_sync <= {sel_sync[0], ADDRESS_SELECT_INPUT};
         scl_q    <= scl_s;
         sda_q    <= sda_s;
      end
   end

   // Acquisition side: staging writes, no reset needed for data
   always @(posedge CLK_SYS) begin
      if (ACQ_WE) begin
         stage_mem[ACQ_ADDR] <= ACQ_DATA;
      end
   end

   // Transfer copy taken only while the bus is idle
   integer k;
   always @(posedge CLK_SYS) begin
      if (copy_now) begin
         for (k = 0; k < STORE_DEPTH; k = k + 1) begin
            xfer_mem[k] <= stage_mem[k];
         end
      end
   end

   // Commit request waits out any bus access; a new commit wins over the clear by a copy, so another copy follows
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         commit_pending <= 1'b0;
         DATA_UPDATED   <= 1'b0;
      end else begin
         commit_pending <= ACQ_COMMIT | (commit_pending & ~copy_now);
         DATA_UPDATED   <= copy_now;
      end
   end

   // Bus protocol engine; SDA changes only after a seen SCL fall
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state              <= ST_IDLE;
         bit_cnt            <= 4'h0;
         rx_shift           <= 8'h00;
         tx_shift           <= 8'hFF;
         rd_dir             <= 1'b0;
         master_acknowledge <= 1'b0;
         byte_ptr           <= 4'h0;
         MODE_CONTROL       <= `VBIRD_CTRL_RESET;
         SDA_O              <= 1'b0;
         SDA_OE             <= 1'b0;
         BUS_BUSY           <= 1'b0;
      end else begin
         BUS_BUSY <= (state != ST_IDLE);
         if (start_det) begin
            // Start, or repeated start, restarts from the first byte
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            byte_ptr <= 4'h0;
            SDA_OE   <= 1'b0;
         end else if (stop_det) begin
            state  <= ST_IDLE;
            SDA_OE <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_WDATA: begin
                  if (scl_rise) begin
                     rx_shift <= {rx_shift[6:0], sda_s};
                     bit_cnt  <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == `VBIRD_BITS_PER_BYTE) begin
                     bit_cnt <= 4'h0;
                     if (state == ST_WDATA) begin
                        MODE_CONTROL <= rx_shift;
                        SDA_OE       <= 1'b1;
                        state        <= ST_WACK;
                     end else if (rx_shift[7:1] == (sel_sync[1] ? `VBIRD_SLAVE_ADDR_HIGH
                                                                : `VBIRD_SLAVE_ADDR_LOW)) begin
                        rd_dir <= rx_shift[0];
                        SDA_OE <= 1'b1;
                        state  <= ST_AACK;
                     end else begin
                        state <= ST_SKIP;
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fall) begin
                     if (rd_dir) begin
                        // Become transmitter with the first bit at once
                        tx_shift <= {out_byte[6:0], 1'b1};
                        SDA_OE   <= ~out_byte[7];
                        state    <= ST_RDATA;
                     end else begin
                        SDA_OE <= 1'b0;
                        state  <= ST_WDATA;
                     end
                  end
               end
               ST_WACK: begin
                  // Only one data byte per write; later bytes go unanswered
                  if (scl_fall) begin
                     SDA_OE <= 1'b0;
                     state  <= ST_SKIP;
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == `VBIRD_BITS_PER_BYTE - 4'h1) begin
                        SDA_OE  <= 1'b0;                         // Release for ack slot
                        bit_cnt <= 4'h0;
                        state   <= ST_RACK;
                     end else begin
                        SDA_OE   <= ~tx_shift[7];
                        tx_shift <= {tx_shift[6:0], 1'b1};
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     master_acknowledge <= ~sda_s;
                     if (sda_s) begin
                        state <= ST_SKIP;
                     end else if (byte_ptr < `VBIRD_MAX_BYTES) begin
                        byte_ptr <= byte_ptr + 4'h1;
                     end
                  end else if (scl_fall && master_acknowledge) begin
                     tx_shift <= {out_byte[6:0], 1'b1};
                     SDA_OE   <= ~out_byte[7];
                     state    <= ST_RDATA;
                  end
               end
               default: begin
                  SDA_OE <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

/* File: testbench/vbird_readout_props.sv */
`timescale 1ns/100ps
// Pin-level checks of the readout slave
module vbird_readout_props #(
   parameter STORE_DEPTH = 128 // Store size, passed on for symmetry only
) (
   input wire       CLK_SYS,
   input wire       RST_N,
   input wire       SCL_I,
   input wire       SDA_I,
   input wire       ADDRESS_SELECT_INPUT,
   input wire       ACQ_WE,
   input wire [6:0] ACQ_ADDR,
   input wire [7:0] ACQ_DATA,
   input wire       ACQ_COMMIT,
   input wire       SDA_O,
   input wire       SDA_OE,
   input wire [7:0] MODE_CONTROL,
   input wire       BUS_BUSY,
   input wire       DATA_UPDATED
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   property p_rst; $rose(RST_N) |-> MODE_CONTROL == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("control not clear");
   property p_od; SDA_O == 1'b0; endproperty
   a_od: assert property (p_od) else $error("data output not low");
   // Control only moves inside a transfer
   property p_ctl; !$stable(MODE_CONTROL) |-> $past(BUS_BUSY); endproperty
   a_ctl: assert property (p_ctl) else $error("control moved when idle");
   // Margin of four clocks covers the one-clock lag of the busy flag
   property p_upd; BUS_BUSY [*4] |-> !DATA_UPDATED; endproperty
   a_upd: assert property (p_upd) else $error("copy during access");
   property p_pulse; DATA_UPDATED |=> !DATA_UPDATED; endproperty
   a_pulse: assert property (p_pulse) else $error("copy pulse too long");
   // Data may only change after the clock has gone low
   property p_low; !$stable(SDA_OE) |-> !$past(SCL_I, 2); endproperty
   a_low: assert property (p_low) else $error("data moved with clock high");
   property p_hold; $rose(SDA_OE) |=> SDA_OE [*4]; endproperty
   a_hold: assert property (p_hold) else $error("low bit too short");
   property p_start; SCL_I && $fell(SDA_I) |-> ##[1:6] BUS_BUSY; endproperty
   a_start: assert property (p_start) else $error("start not seen");
   property p_stop; SCL_I && $rose(SDA_I) |-> ##[1:6] !BUS_BUSY; endproperty
   a_stop: assert property (p_stop) else $error("stop not seen");
   c_upd: cover property (DATA_UPDATED);
   c_ctl: cover property (!$stable(MODE_CONTROL));
   c_drv: cover property ($rose(SDA_OE));
endmodule

bind vbird_i2c_readout vbird_readout_props #(.STORE_DEPTH(STORE_DEPTH)) props_i (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCL_I(SCL_I), .SDA_I(SDA_I),
   .ADDRESS_SELECT_INPUT(ADDRESS_SELECT_INPUT), .ACQ_WE(ACQ_WE), .ACQ_ADDR(ACQ_ADDR),
   .ACQ_DATA(ACQ_DATA), .ACQ_COMMIT(ACQ_COMMIT), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .MODE_CONTROL(MODE_CONTROL), .BUS_BUSY(BUS_BUSY), .DATA_UPDATED(DATA_UPDATED));

/* File: testbench/vbird_i2c_master.sv */
`timescale 1ns/100ps
// Behavioural bus master, bus clock of eight system clocks (320 ns), open-drain data line
// Lines move by non-blocking assignment on a system clock edge, so no race with sampling
module vbird_i2c_master (
   input  wire clk,
   input  wire sda_oe,
   output reg  scl,
   output wire sda
);
   reg sda_drv = 1'b1;             // Master half of the line, 1 = released
   assign sda = sda_drv & ~sda_oe; // Pull-up level only when nobody pulls low
   initial scl = 1'b1;
   // Start, also used as repeated start
   task start;
      begin
         @(posedge clk);
         sda_drv <= 1'b1;
         repeat (2) @(posedge clk);
         scl <= 1'b1;
         repeat (4) @(posedge clk);
         sda_drv <= 1'b0;
         repeat (4) @(posedge clk);
         scl <= 1'b0;
      end
   endtask
   // Nine pulses; tx[0] is the master's ninth bit, 1 releases the line
   task xfer(input [8:0] tx, output [8:0] rx);
      integer i;
      begin
         for (i = 8; i >= 0; i = i - 1) begin
            repeat (2) @(posedge clk);
            sda_drv <= tx[i];
            repeat (2) @(posedge clk);
            scl <= 1'b1;
            repeat (3) @(posedge clk);
            // Sample mid-cycle, away from the edge that moves the slave's drive
            @(negedge clk);
            rx[i] = sda;
            @(posedge clk);
            scl <= 1'b0;
         end
      end
   endtask
   // Stop, then bus stays free
   task stop;
      begin
         repeat (2) @(posedge clk);
         sda_drv <= 1'b0;
         repeat (2) @(posedge clk);
         scl <= 1'b1;
         repeat (4) @(posedge clk);
         sda_drv <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "vbird_regs.vh"
module tb_top;
   reg        CLK_SYS, RST_N, ADDRESS_SELECT_INPUT, ACQ_WE, ACQ_COMMIT;
   reg  [6:0] ACQ_ADDR;
   reg  [7:0] ACQ_DATA;
   wire       SCL_I, SDA_I, SDA_O, SDA_OE, BUS_BUSY, DATA_UPDATED;
   wire [7:0] MODE_CONTROL;
   reg  [7:0] sd;        // Seed of data now readable
   reg  [7:0] ns;        // Seed of data staged
   reg  [8:0] rx;        // Bits the master saw
   integer    err_count, n_tests, m, k;
   integer    n_upd = 0; // Store copies seen
   vbird_i2c_readout vbird_i2c_readout_i (
      .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCL_I(SCL_I), .SDA_I(SDA_I),
      .ADDRESS_SELECT_INPUT(ADDRESS_SELECT_INPUT), .ACQ_WE(ACQ_WE), .ACQ_ADDR(ACQ_ADDR),
      .ACQ_DATA(ACQ_DATA), .ACQ_COMMIT(ACQ_COMMIT), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
      .MODE_CONTROL(MODE_CONTROL), .BUS_BUSY(BUS_BUSY), .DATA_UPDATED(DATA_UPDATED));
   vbird_i2c_master mst (.clk(CLK_SYS), .sda_oe(SDA_OE), .scl(SCL_I), .sda(SDA_I));
   initial begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      if (DATA_UPDATED === 1'b1) n_upd <= n_upd + 1;
   end
   function [7:0] rv(input [7:0] b);
      integer i;
      for (i = 0; i < 8; i = i + 1) rv[7 - i] = b[i];
   endfunction
   // Source byte n of bank 0 for seed s
   function [7:0] sb(input [7:0] s, input [5:0] n);
      sb = {n, 2'b10} ^ s;
   endfunction
   // Expected byte k of view v: first received bit goes out first
   function [7:0] ex(input [1:0] v, input [3:0] k);
      reg [5:0] a;
      begin
         case (v)
            `VBIRD_VIEW_VPS: a = k < 5 ? k + 10 : (k == 5 ? 5 : 15);
            `VBIRD_VIEW_FMT2: a = k < 5 ? 14 + 2 * k : (k == 5 ? 14 : (k == 6 ? 24 : 13));
            `VBIRD_VIEW_FMT1: a = k < 8 ? k + 14 : (k < 10 ? k + 5 : k + 12);
            default: a = k + 37;
         endcase
         if (v == `VBIRD_VIEW_FMT2)
            ex = rv({k == 7 ? 4'hF : a[3:0] + 4'h1 ^ sd[3:0], a[3:0] ^ sd[3:0]});
         else
            ex = (v == `VBIRD_VIEW_VPS && k == 7) ? 8'hFF : rv(sb(sd, a));
      end
   endfunction
   function [7:0] ctl(input [1:0] v);
      ctl = v == 0 ? 8'h00 : (v == 1 ? 8'h02 : (v == 2 ? 8'h03 : 8'h07));
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("mismatches %0d, checks %0d", err_count, n_tests);
         if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Stage both banks with seed s, then ask for a copy
   task fill(input [7:0] s);
      integer n;
      begin
         ns = s;
         for (n = 0; n < 128; n = n + 1) begin
            @(posedge CLK_SYS);
            ACQ_WE <= 1'b1;
            ACQ_ADDR <= n[6:0];
            ACQ_DATA <= n[6] ? {4'h0, n[3:0] ^ s[3:0]} : sb(s, n[5:0]);
         end
         @(posedge CLK_SYS);
         ACQ_WE <= 1'b0;
         ACQ_COMMIT <= 1'b1;
         @(posedge CLK_SYS);
         ACQ_COMMIT <= 1'b0;
      end
   endtask
   // Bounded wait for copy number c
   task wait_upd(input integer c);
      integer t;
      begin
         for (t = 0; t < 100 && n_upd != c; t = t + 1) @(negedge CLK_SYS);
         chk(n_upd == c, 1'b1);
         if (n_upd != c) final_report;
         sd = ns;
      end
   endtask
   task wr(input [6:0] sa, input [7:0] d, input ack);
      begin
         mst.start;
         mst.xfer({sa, 2'b01}, rx);
         chk(rx[0], ack);
         mst.xfer({d, 1'b1}, rx);
         if (!ack) chk(rx[0], 1'b0);
         mst.stop;
      end
   endtask
   task rd(input [1:0] v, input [3:0] n, input [6:0] sa, input ack);
      integer j;
      begin
         mst.start;
         mst.xfer({sa, 2'b11}, rx);
         chk(rx[0], ack);
         for (j = 1; j <= n; j = j + 1) begin
            mst.xfer({8'hFF, j == n}, rx);
            chk(rx[8:1], ex(v, j));
         end
         repeat (5) @(negedge CLK_SYS);
         chk(SDA_OE, 1'b0);
         mst.stop;
      end
   endtask
   initial begin
      RST_N = 1'b0;
      ADDRESS_SELECT_INPUT = 1'b0;
      ACQ_WE = 1'b0;
      ACQ_ADDR = 7'h00;
      ACQ_DATA = 8'h00;
      ACQ_COMMIT = 1'b0;
      err_count = 0;
      n_tests = 0;
      sd = 8'h00;
      repeat (4) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      @(negedge CLK_SYS);
      chk(MODE_CONTROL, `VBIRD_CTRL_RESET);
      fill(8'h5A);
      wait_upd(1);
      // Every view, read to its full length after a fresh start
      for (m = 0; m < 4; m = m + 1) begin
         wr(`VBIRD_SLAVE_ADDR_LOW, ctl(m), 1'b0);
         chk(MODE_CONTROL, ctl(m));
         k = m == 2 ? 13 : (m == 3 ? 8 : 7);
         rd(m, k, `VBIRD_SLAVE_ADDR_LOW, 1'b0);
      end
      wr(`VBIRD_SLAVE_ADDR_HIGH, 8'h02, 1'b1);
      chk(MODE_CONTROL, 8'h07);
      ADDRESS_SELECT_INPUT <= 1'b1;
      repeat (4) @(posedge CLK_SYS);
      wr(`VBIRD_SLAVE_ADDR_LOW, 8'h00, 1'b1);
      chk(MODE_CONTROL, 8'h07);
      wr(`VBIRD_SLAVE_ADDR_HIGH, 8'h02, 1'b0);
      chk(MODE_CONTROL, 8'h02);
      rd(1, 7, `VBIRD_SLAVE_ADDR_HIGH, 1'b0);
      // Commit while a read holds the bus: old data must still come out
      mst.start;
      mst.xfer({`VBIRD_SLAVE_ADDR_HIGH, 2'b11}, rx);
      fill(8'hC3);
      mst.xfer({8'hFF, 1'b1}, rx);
      chk(rx[8:1], ex(1, 1));
      chk(n_upd, 1);
      mst.stop;
      wait_upd(2);
      rd(1, 2, `VBIRD_SLAVE_ADDR_HIGH, 1'b0);
      // Reset in mid-run clears a non-zero control byte, then the bus works again
      @(posedge CLK_SYS);
      RST_N <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      @(negedge CLK_SYS);
      chk(MODE_CONTROL, `VBIRD_CTRL_RESET);
      wr(`VBIRD_SLAVE_ADDR_HIGH, 8'h03, 1'b0);
      chk(MODE_CONTROL, 8'h03);
      final_report;
   end
endmodule
